//--- logic/ccp_codec_control_port.sv
`timescale 1ns/1ps
module ccp_codec_control_port #(
    parameter int unsigned RAMP_CYCLES = ccp_pkg::RAMP_CYCLES
) (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic ADDR_PIN_LOW_OR_CHIP_SELECT_IN,
    input wire logic ADDR_SELECT_HIGH_IN,
    input wire logic CTRL_BIT_CLOCK_IN,
    input wire logic CTRL_SERIAL_IN,
    output logic CTRL_SERIAL_OUT_OUT,
    output logic CTRL_SERIAL_OUT_OE_OUT,
    input wire logic [ccp_pkg::NUM_IRQ-1:0] IRQ_SOURCE_IN,
    input wire logic [ccp_pkg::NUM_IRQ-1:0] IRQ_CLEAR_IN,
    input wire ccp_pkg::ccp_irq_cfg_t INT_CFG_IN,
    output logic INT_OUT,
    output logic INT_OE_OUT,
    input wire logic PLL_SELECTED_IN,
    input wire logic PLL_LOCKED_IN,
    input wire logic [6:0] CFG_ADDR_IN,
    output logic [7:0] CFG_DATA_OUT,
    output ccp_pkg::ccp_power_t POWER_STATE_OUT
);

// ------------------------------------------------------------
// Pin resynchronisation
// ------------------------------------------------------------
// A pin level counts only once the second and third stages agree,
// which costs latency but rejects a single metastable sample.
logic [3:0] pins_w;
logic [3:0] s1_q;
logic [3:0] s2_q;
logic [3:0] s3_q;
logic [3:0] flt_q;
logic [3:0] prev_q;
logic [3:0] agree_w;
logic [3:0] flt_d;
assign pins_w = {CTRL_SERIAL_IN, CTRL_BIT_CLOCK_IN,
                 ADDR_SELECT_HIGH_IN, ADDR_PIN_LOW_OR_CHIP_SELECT_IN};
assign agree_w = ~(s2_q ^ s3_q);
assign flt_d = (agree_w & s2_q) | (~agree_w & flt_q);

always_ff @(posedge CLK_IN) begin
    s1_q <= pins_w;
    s2_q <= s1_q;
    s3_q <= s2_q;
end

// Seeding from the pins at reset avoids a false edge at release.
always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
        flt_q <= s2_q;
        prev_q <= s2_q;
    end else begin
        flt_q <= flt_d;
        prev_q <= flt_q;
    end
end

logic cs_high_w;
logic cs_fall_w;
logic sclk_rise_w;
logic sclk_fall_w;
logic sda_w;
logic i2c_start_w;
logic i2c_stop_w;
assign cs_high_w = flt_q[0];
assign cs_fall_w = prev_q[0] & ~flt_q[0];
assign sclk_rise_w = flt_q[2] & ~prev_q[2];
assign sclk_fall_w = ~flt_q[2] & prev_q[2];
assign sda_w = flt_q[3];
assign i2c_start_w = prev_q[3] & ~flt_q[3] & flt_q[2] & prev_q[2];
assign i2c_stop_w = ~prev_q[3] & flt_q[3] & flt_q[2] & prev_q[2];

// ------------------------------------------------------------
// Mode and address strap
// ------------------------------------------------------------
logic [1:0] strap_q;
logic spi_mode_q;
logic spi_w;

always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
        strap_q <= {s2_q[1], s2_q[0]};
    end
end

always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
        spi_mode_q <= 1'b0;
    end else if (cs_fall_w) begin
        spi_mode_q <= 1'b1;
    end
end
assign spi_w = spi_mode_q | cs_fall_w;

// ------------------------------------------------------------
// Helpers
// ------------------------------------------------------------
function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic inc);
    step_ptr = inc ? 7'(p + 7'h01) : p;
endfunction

function automatic logic addr_match(input logic [7:0] b, input logic spi,
                                    input logic [1:0] strap);
    if (spi) begin
        addr_match = (b[7:1] == ccp_pkg::SPI_DEV_ADDR);
    end else begin
        addr_match = (b[7:1] == {ccp_pkg::I2C_ADDR_HI, strap});
    end
endfunction

// ------------------------------------------------------------
// Serial engine
// ------------------------------------------------------------
ccp_pkg::ccp_state_t st_q;
logic [2:0] bit_q;
logic [7:0] sh_q;
logic [7:0] tx_q;
logic [3:0] tx_cnt_q;
logic [6:0] ptr_q;
logic autostep_q;
logic ack_due_q;
logic ack_on_q;
logic out_bit_q;
logic out_en_q;
logic [7:0] regs_q [0:ccp_pkg::NUM_REGS-1];

logic rx_state_w;
logic rx_en_w;
logic rx_done_w;
logic [7:0] rx_byte_w;
logic [6:0] ptr_next_w;
logic wr_en_w;
assign rx_state_w = (st_q == ccp_pkg::CCP_ADDR) || (st_q == ccp_pkg::CCP_PTR) ||
                    (st_q == ccp_pkg::CCP_WDATA);
assign rx_en_w = sclk_rise_w && rx_state_w && !ack_on_q;
assign rx_byte_w = {sh_q[6:0], sda_w};
assign rx_done_w = rx_en_w && (bit_q == ccp_pkg::BIT_LAST);
assign ptr_next_w = step_ptr(ptr_q, autostep_q);
assign wr_en_w = rx_done_w && (st_q == ccp_pkg::CCP_WDATA);

always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
        st_q <= ccp_pkg::CCP_IDLE;
        bit_q <= 3'h0;
        sh_q <= 8'h00;
        tx_q <= 8'h00;
        tx_cnt_q <= 4'h0;
        ptr_q <= 7'h00;
        autostep_q <= 1'b0;
        ack_due_q <= 1'b0;
        ack_on_q <= 1'b0;
        out_bit_q <= 1'b0;
        out_en_q <= 1'b0;
    end else if (spi_w && cs_high_w) begin
        st_q <= ccp_pkg::CCP_IDLE;
        out_en_q <= 1'b0;
    end else if (spi_w && cs_fall_w) begin
        st_q <= ccp_pkg::CCP_ADDR;
        bit_q <= 3'h0;
        out_en_q <= 1'b0;
    end else if (!spi_w && (i2c_start_w || i2c_stop_w)) begin
        st_q <= i2c_start_w ? ccp_pkg::CCP_ADDR : ccp_pkg::CCP_IDLE;
        bit_q <= 3'h0;
        ack_due_q <= 1'b0;
        ack_on_q <= 1'b0;
        out_en_q <= 1'b0;
    end else begin
        if (rx_en_w) begin
            sh_q <= rx_byte_w;
            bit_q <= 3'(bit_q + 3'h1);
        end
        if (rx_done_w) begin
            case (st_q)
                ccp_pkg::CCP_ADDR: begin
                    if (addr_match(rx_byte_w, spi_w, strap_q)) begin
                        st_q <= rx_byte_w[0] ? ccp_pkg::CCP_RDATA : ccp_pkg::CCP_PTR;
                        tx_q <= regs_q[ptr_q];
                        tx_cnt_q <= 4'h0;
                        ack_due_q <= !spi_w;
                    end else begin
                        st_q <= ccp_pkg::CCP_IGNORE;
                    end
                end
                ccp_pkg::CCP_PTR: begin
                    ptr_q <= rx_byte_w[6:0];
                    autostep_q <= rx_byte_w[ccp_pkg::AUTOSTEP_BIT];
                    st_q <= ccp_pkg::CCP_WDATA;
                    ack_due_q <= !spi_w;
                end
                ccp_pkg::CCP_WDATA: begin
                    ptr_q <= ptr_next_w;
                    ack_due_q <= !spi_w;
                end
                default: begin
                end
            endcase
        end
        if (!spi_w && sclk_rise_w && (st_q == ccp_pkg::CCP_RDATA) &&
            (tx_cnt_q == ccp_pkg::TX_WAIT_ACK)) begin
            if (!sda_w) begin
                tx_q <= regs_q[ptr_next_w];
                ptr_q <= ptr_next_w;
                tx_cnt_q <= 4'h0;
            end else begin
                st_q <= ccp_pkg::CCP_IGNORE;
            end
        end
        if (sclk_fall_w && spi_w && (st_q == ccp_pkg::CCP_RDATA)) begin
            out_en_q <= 1'b1;
            out_bit_q <= tx_q[7];
            if (tx_cnt_q == ccp_pkg::TX_LAST_BIT) begin
                tx_q <= regs_q[ptr_next_w];
                ptr_q <= ptr_next_w;
                tx_cnt_q <= 4'h0;
            end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                tx_cnt_q <= 4'(tx_cnt_q + 4'h1);
            end
        end
        if (sclk_fall_w && !spi_w) begin
            if (ack_due_q) begin
                out_en_q <= 1'b1;
                out_bit_q <= 1'b0;
                ack_due_q <= 1'b0;
                ack_on_q <= 1'b1;
            end else begin
                if (ack_on_q) begin
                    out_en_q <= 1'b0;
                    ack_on_q <= 1'b0;
                end
                if (st_q == ccp_pkg::CCP_RDATA) begin
                    if (tx_cnt_q < ccp_pkg::TX_BYTE_END) begin
                        out_en_q <= 1'b1;
                        out_bit_q <= tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                        tx_cnt_q <= 4'(tx_cnt_q + 4'h1);
                    end else if (tx_cnt_q == ccp_pkg::TX_BYTE_END) begin
                        out_en_q <= 1'b0;
                        tx_cnt_q <= ccp_pkg::TX_WAIT_ACK;
                    end
                end
            end
        end
    end
end

// The I2C data line is open drain: only a zero is ever driven.
assign CTRL_SERIAL_OUT_OUT = spi_mode_q ? out_bit_q : 1'b0;
assign CTRL_SERIAL_OUT_OE_OUT = spi_mode_q ? out_en_q : (out_en_q & ~out_bit_q);

// ------------------------------------------------------------
// Register file
// ------------------------------------------------------------
always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
        for (int i = 0; i < ccp_pkg::NUM_REGS; i++) begin
            regs_q[i] <= (7'(i) == ccp_pkg::PWR_CTRL_IDX) ?
                         ccp_pkg::PWR_CTRL_RST : ccp_pkg::REG_RST;
        end
    end else if (wr_en_w) begin
        regs_q[ptr_q] <= rx_byte_w;
    end
end

always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
        CFG_DATA_OUT <= 8'h00;
    end else begin
        CFG_DATA_OUT <= regs_q[CFG_ADDR_IN];
    end
end

// ------------------------------------------------------------
// Power, settling and mute
// ------------------------------------------------------------
logic [ccp_pkg::RAMP_CNT_W-1:0] ramp_q;
logic pdn_w;
logic pll_wait_w;
logic mute_w;
assign pdn_w = regs_q[ccp_pkg::PWR_CTRL_IDX][ccp_pkg::PDN_BIT];
assign pll_wait_w = PLL_SELECTED_IN & ~PLL_LOCKED_IN;
assign mute_w = (ramp_q != '0) | pdn_w | pll_wait_w;

always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
        ramp_q <= ccp_pkg::RAMP_CNT_W'(RAMP_CYCLES);
        POWER_STATE_OUT <= '{low_power: 1'b1, mute: 1'b1, audio_en: 1'b0};
    end else begin
        if (ramp_q != '0) begin
            ramp_q <= ramp_q - 1'b1;
        end
        POWER_STATE_OUT <= '{low_power: pdn_w, mute: mute_w, audio_en: ~mute_w};
    end
end

// ------------------------------------------------------------
// Interrupt output
// ------------------------------------------------------------
logic [ccp_pkg::NUM_IRQ-1:0] src_prev_q;
logic [ccp_pkg::NUM_IRQ-1:0] pend_q;
logic [ccp_pkg::NUM_IRQ-1:0] pend_d;
logic [ccp_pkg::NUM_IRQ-1:0] act_w;
logic int_any_w;

always_comb begin
    pend_d = '0;
    act_w = '0;
    for (int i = 0; i < ccp_pkg::NUM_IRQ; i++) begin
        pend_d[i] = (pend_q[i] & ~IRQ_CLEAR_IN[i]) |
            ((INT_CFG_IN.trig[i] == ccp_pkg::CCP_TRIG_RISE) &
             IRQ_SOURCE_IN[i] & ~src_prev_q[i]) |
            ((INT_CFG_IN.trig[i] == ccp_pkg::CCP_TRIG_FALL) &
             ~IRQ_SOURCE_IN[i] & src_prev_q[i]);
        act_w[i] = (INT_CFG_IN.trig[i] == ccp_pkg::CCP_TRIG_LEVEL) ?
                   IRQ_SOURCE_IN[i] : pend_q[i];
    end
end
assign int_any_w = |(act_w & INT_CFG_IN.mask);

always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
        src_prev_q <= '0;
        pend_q <= '0;
        INT_OUT <= 1'b0;
        INT_OE_OUT <= 1'b0;
    end else begin
        src_prev_q <= IRQ_SOURCE_IN;
        pend_q <= pend_d;
        case (INT_CFG_IN.mode)
            ccp_pkg::CCP_INT_LOW_PP: begin
                INT_OUT <= ~int_any_w;
                INT_OE_OUT <= 1'b1;
            end
            ccp_pkg::CCP_INT_HIGH_PP: begin
                INT_OUT <= int_any_w;
                INT_OE_OUT <= 1'b1;
            end
            default: begin
                INT_OUT <= 1'b0;
                INT_OE_OUT <= int_any_w;
            end
        endcase
    end
end

// ------------------------------------------------------------
// Checks
// ------------------------------------------------------------
mode_spi_a:
assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    cs_fall_w |=> spi_mode_q [*2])
    else $error("chip select fall did not select SPI mode");
strap_hold_a:
assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    1'b1 |=> $stable(strap_q))
    else $error("address strap changed after reset release");
spi_launch_a:
assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    spi_mode_q && $changed(out_bit_q) |-> $past(sclk_fall_w) || $past(ack_due_q))
    else $error("serial output changed off a falling clock");
spi_wr_hiz_a:
assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    spi_mode_q && (st_q == ccp_pkg::CCP_PTR || st_q == ccp_pkg::CCP_WDATA)
    |-> !CTRL_SERIAL_OUT_OE_OUT)
    else $error("serial output driven during SPI write");
ptr_step_a:
assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    wr_en_w |=> ptr_q == 7'($past(ptr_q) + {6'h00, $past(autostep_q)}))
    else $error("pointer step wrong after write byte");
rd_msb_a:
assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    spi_mode_q && !cs_high_w && st_q == ccp_pkg::CCP_RDATA && sclk_fall_w &&
    tx_cnt_q == 4'h0 |=> CTRL_SERIAL_OUT_OE_OUT && CTRL_SERIAL_OUT_OUT == $past(tx_q[7]))
    else $error("read MSB not driven on falling edge");
ptr_load_a:
assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    rx_done_w && st_q == ccp_pkg::CCP_PTR
    |=> ptr_q == $past(rx_byte_w[6:0]) && autostep_q == $past(rx_byte_w[7]))
    else $error("pointer byte not split into flag and address");
start_det_a:
assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !spi_w && i2c_start_w |=> st_q == ccp_pkg::CCP_ADDR && bit_q == 3'h0)
    else $error("start condition not taken");
no_ack_a:
assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !spi_mode_q && st_q == ccp_pkg::CCP_IGNORE |-> !CTRL_SERIAL_OUT_OE_OUT)
    else $error("foreign address was acknowledged");
ack_low_a:
assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !spi_mode_q && ack_on_q |-> CTRL_SERIAL_OUT_OE_OUT)
    else $error("acknowledge slot not driven low");
ramp_mute_a:
assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    ramp_q != '0 |=> POWER_STATE_OUT.mute && !POWER_STATE_OUT.audio_en)
    else $error("outputs not muted during reference ramp");
pll_hold_a:
assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    pll_wait_w |=> !POWER_STATE_OUT.audio_en)
    else $error("audio enabled before PLL settled");
od_int_a:
assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    INT_CFG_IN.mode == ccp_pkg::CCP_INT_LOW_OD |=> !INT_OUT)
    else $error("open drain interrupt drove high");

endmodule

//--- logic/ccp_pkg.sv
// Overview of operation
// - A falling chip select after reset release switches the port to SPI mode.
// - Both address-select pins are sampled during reset as I2C address bits.
// - SPI input bits sampled on rising clock, output launched on falling clock.
// - The serial output stays high impedance through an SPI write.
// - With auto-step set the pointer advances per byte, otherwise it holds.
// - After an SPI read address the next falling edge drives the register MSB; in I2C the acknowledge comes first.
// - SPI read with auto-step streams consecutive registers while clocks continue.
// - The pointer byte is eight bits, most significant bit first.
// - I2C answers only address 10011 plus strapped bits; bit eight is read.
// - Start is data falling with clock high; stop is data rising.
// - In I2C write the first byte is the pointer, then register data.
// - Device acknowledges each received byte; host acknowledges each sent byte.
// - Interrupt pin is low push-pull, high push-pull, or low open drain.
// - Each interrupt source has a mask and rising, falling or level trigger.
// - Reset clears the serial engine, interrupt state and registers except power control (reset to 81h), loads the ramp count and holds outputs muted, low power.
// - After reset the port works; writing power-down zero starts operation.
// - With the PLL selected, serial audio outputs wait until it has settled.
// - All ports and converters are muted about 80 ms after reset exit.
// - Control pins are resynchronised and need no relation to audio clocks.
package ccp_pkg;
    localparam logic [6:0] SPI_DEV_ADDR = 7'h4f;
    localparam logic [4:0] I2C_ADDR_HI = 5'h13;
    localparam int unsigned NUM_REGS = 128;
    localparam logic [6:0] PWR_CTRL_IDX = 7'h02;
    localparam logic [7:0] PWR_CTRL_RST = 8'h81;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int unsigned PDN_BIT = 0;
    localparam int unsigned AUTOSTEP_BIT = 7;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] TX_LAST_BIT = 4'h7;
    localparam logic [3:0] TX_BYTE_END = 4'h8;
    localparam logic [3:0] TX_WAIT_ACK = 4'h9;
    localparam int unsigned NUM_IRQ = 4;
    localparam longint unsigned CLK_HZ = 125000000;
    localparam longint unsigned RAMP_MS = 80;
    localparam longint unsigned MS_PER_S = 1000;
    localparam int unsigned RAMP_CYCLES = int'((RAMP_MS * CLK_HZ) / MS_PER_S);
    localparam int unsigned RAMP_CNT_W = 24;

    typedef enum logic [2:0] {
        CCP_IDLE = 3'b000,
        CCP_ADDR = 3'b001,
        CCP_PTR = 3'b010,
        CCP_WDATA = 3'b011,
        CCP_RDATA = 3'b100,
        CCP_IGNORE = 3'b101
    } ccp_state_t;

    typedef enum logic [1:0] {
        CCP_TRIG_LEVEL = 2'b00,
        CCP_TRIG_RISE = 2'b01,
        CCP_TRIG_FALL = 2'b10
    } ccp_trig_t;

    typedef enum logic [1:0] {
        CCP_INT_LOW_PP = 2'b00,
        CCP_INT_HIGH_PP = 2'b01,
        CCP_INT_LOW_OD = 2'b10
    } ccp_int_mode_t;

    typedef struct packed {
        logic [NUM_IRQ-1:0] mask;
        ccp_trig_t [NUM_IRQ-1:0] trig;
        ccp_int_mode_t mode;
    } ccp_irq_cfg_t;

    typedef struct packed {
        logic low_power;
        logic mute;
        logic audio_en;
    } ccp_power_t;
endpackage

//--- verif/ccp_host_model.sv
`timescale 1ns/1ps
module ccp_host_model (
    input wire logic clk_in,
    input wire logic dout_in,
    input wire logic oe_in,
    output logic cs_out,
    output logic sclk_out,
    output logic din_out
);
    logic i2c_mode = 1'b0;
    logic mosi = 1'b1;
    logic sda_low = 1'b0;
    int oe_hits = 0;

    initial begin
        cs_out = 1'b1;
        sclk_out = 1'b1;
    end

    // A released data wire floats high through its pull-up, never at the last value.
    assign din_out = i2c_mode ? ~(sda_low | oe_in) : mosi;

    // ----------------------------------------
    // Link timing
    // ----------------------------------------
    // Half a link period of 40 ns, changed only on falling system clock edges.
    task automatic half();
        repeat (5) @(negedge clk_in);
    endtask

    task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk_out = 1'b0;
            mosi = tx[i];
            half();
            sclk_out = 1'b1;
            half();
            // An undriven output line shows the opposite of its last value here.
            rx[i] = oe_in ? dout_in : ~dout_in;
            if (oe_in) begin
                oe_hits++;
            end
        end
    endtask

    // The data line is left where it was between frames so the pins stay quiet.
    task automatic spi_frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
        logic [7:0] b;
        rx = {};
        cs_out = 1'b0;
        half();
        foreach (tx[k]) begin
            spi_byte(tx[k], b);
            rx.push_back(b);
        end
        half();
        cs_out = 1'b1;
        half();
        half();
    endtask

    task automatic i2c_start();
        i2c_mode = 1'b1;
        sda_low = 1'b0;
        sclk_out = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        sclk_out = 1'b0;
        half();
    endtask

    task automatic i2c_stop();
        sda_low = 1'b1;
        half();
        sclk_out = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask

    task automatic i2c_byte(input logic [7:0] tx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low = ~tx[i];
            half();
            sclk_out = 1'b1;
            half();
            sclk_out = 1'b0;
        end
        sda_low = 1'b0;
        half();
        sclk_out = 1'b1;
        half();
        ack = ~din_out;
        sclk_out = 1'b0;
    endtask

    // The host releases the data line for eight bits, then acknowledges unless last.
    task automatic i2c_read(input logic last, output logic [7:0] data);
        for (int i = 7; i >= 0; i--) begin
            sda_low = 1'b0;
            half();
            sclk_out = 1'b1;
            half();
            data[i] = din_out;
            sclk_out = 1'b0;
        end
        sda_low = ~last;
        half();
        sclk_out = 1'b1;
        half();
        sclk_out = 1'b0;
    endtask
endmodule

//--- verif/codec_control_port_bench.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
end
module codec_control_port_bench;
    // Short ramp so the mute interval can be watched from start to end.
    localparam int unsigned RAMP = 400;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs, sclk, din, dout, dout_oe, int_pin, int_oe, ack;
    logic addr_hi = 1'b0;
    logic pll_sel = 1'b0;
    logic pll_lock = 1'b0;
    logic [3:0] src = 4'h0;
    logic [3:0] clr = 4'h0;
    logic [6:0] cfg_addr = 7'h00;
    logic [7:0] cfg_data;
    ccp_pkg::ccp_irq_cfg_t int_cfg = '0;
    ccp_pkg::ccp_power_t pwr;
    logic [7:0] rx[$];
    logic [7:0] rd;
    int errors = 0;
    int num_checks = 0;

    always #4 clk = ~clk;

    ccp_codec_control_port #(.RAMP_CYCLES(RAMP)) i_ccp_codec_control_port (
        .CLK_IN(clk), .RESET_N_IN(rst_n),
        .ADDR_PIN_LOW_OR_CHIP_SELECT_IN(cs), .ADDR_SELECT_HIGH_IN(addr_hi),
        .CTRL_BIT_CLOCK_IN(sclk), .CTRL_SERIAL_IN(din),
        .CTRL_SERIAL_OUT_OUT(dout), .CTRL_SERIAL_OUT_OE_OUT(dout_oe),
        .IRQ_SOURCE_IN(src), .IRQ_CLEAR_IN(clr), .INT_CFG_IN(int_cfg),
        .INT_OUT(int_pin), .INT_OE_OUT(int_oe),
        .PLL_SELECTED_IN(pll_sel), .PLL_LOCKED_IN(pll_lock),
        .CFG_ADDR_IN(cfg_addr), .CFG_DATA_OUT(cfg_data), .POWER_STATE_OUT(pwr)
    );

    ccp_host_model i_ccp_host_model (
        .clk_in(clk), .dout_in(dout), .oe_in(dout_oe),
        .cs_out(cs), .sclk_out(sclk), .din_out(din)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    task automatic check_reg(input logic [6:0] idx, input logic [7:0] exp);
        cfg_addr = idx;
        repeat (2) @(negedge clk);
        `CHK("register", exp, cfg_data)
    endtask

    task automatic irq_edge(input ccp_pkg::ccp_trig_t t, input logic [3:0] a,
                            input logic [3:0] b);
        int_cfg.trig[1] = t;
        @(negedge clk);
        src = a;
        clr = 4'h2;
        repeat (3) @(negedge clk);
        clr = 4'h0;
        repeat (3) @(negedge clk);
        `CHK("edge idle", 1'b0, int_oe)
        src = b;
        repeat (3) @(negedge clk);
        `CHK("edge seen", 1'b1, int_oe)
        src = a;
        repeat (3) @(negedge clk);
        `CHK("edge held", 1'b1, int_oe)
        clr = 4'h2;
        @(negedge clk);
        clr = 4'h0;
        repeat (3) @(negedge clk);
        `CHK("edge cleared", 1'b0, int_oe)
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_power();
        check_reg(ccp_pkg::PWR_CTRL_IDX, ccp_pkg::PWR_CTRL_RST);
        `CHK("low power", 1'b1, pwr.low_power)
        `CHK("mute", 1'b1, pwr.mute)
        i_ccp_host_model.spi_frame('{8'h9e, 8'h02, 8'h80}, rx);
        check_reg(ccp_pkg::PWR_CTRL_IDX, 8'h80);
        `CHK("low power off", 1'b0, pwr.low_power)
        `CHK("ramp mute", 1'b1, pwr.mute)
        repeat (RAMP) @(negedge clk);
        `CHK("audio on", 1'b1, pwr.audio_en)
        pll_sel = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("pll mute", 1'b1, pwr.mute)
        pll_lock = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("pll ready", 1'b0, pwr.mute)
        $display("test power done");
    endtask

    task automatic test_spi();
        i_ccp_host_model.oe_hits = 0;
        i_ccp_host_model.spi_frame('{8'h9e, 8'h90, 8'ha5, 8'h5a}, rx);
        `CHK("write drive", 0, i_ccp_host_model.oe_hits)
        check_reg(7'h10, 8'ha5);
        check_reg(7'h11, 8'h5a);
        i_ccp_host_model.spi_frame('{8'h9e, 8'h90}, rx);
        i_ccp_host_model.spi_frame('{8'h9f, 8'h00, 8'h00}, rx);
        `CHK("read first", 8'ha5, rx[1])
        `CHK("read next", 8'h5a, rx[2])
        i_ccp_host_model.spi_frame('{8'h9e, 8'h12, 8'h11, 8'h22}, rx);
        check_reg(7'h12, 8'h22);
        check_reg(7'h13, 8'h00);
        i_ccp_host_model.spi_frame('{8'h9e, 8'h11}, rx);
        i_ccp_host_model.spi_frame('{8'h9f, 8'h00, 8'h00}, rx);
        `CHK("held read", 8'h5a, rx[2])
        i_ccp_host_model.spi_frame('{8'h9c, 8'h10, 8'hff}, rx);
        check_reg(7'h10, 8'ha5);
        $display("test spi done");
    endtask

    task automatic test_irq();
        int_cfg.mode = ccp_pkg::CCP_INT_HIGH_PP;
        int_cfg.mask = 4'h1;
        src = 4'h1;
        repeat (3) @(negedge clk);
        `CHK("high active", 1'b1, int_pin)
        int_cfg.mode = ccp_pkg::CCP_INT_LOW_PP;
        repeat (3) @(negedge clk);
        `CHK("low active", 1'b0, int_pin)
        `CHK("low drive", 1'b1, int_oe)
        int_cfg.mode = ccp_pkg::CCP_INT_LOW_OD;
        repeat (3) @(negedge clk);
        `CHK("shared drive", 1'b1, int_oe)
        int_cfg.mask = 4'h0;
        repeat (3) @(negedge clk);
        `CHK("masked", 1'b0, int_oe)
        src = 4'h0;
        int_cfg.mask = 4'h2;
        irq_edge(ccp_pkg::CCP_TRIG_FALL, 4'h2, 4'h0);
        irq_edge(ccp_pkg::CCP_TRIG_RISE, 4'h0, 4'h2);
        $display("test irq done");
    endtask

    task automatic test_i2c();
        i_ccp_host_model.i2c_mode = 1'b1;
        do_reset();
        addr_hi = 1'b1;
        i_ccp_host_model.i2c_start();
        i_ccp_host_model.i2c_byte(8'h9a, ack);
        `CHK("address ack", 1'b1, ack)
        i_ccp_host_model.i2c_byte(8'ha0, ack);
        `CHK("pointer ack", 1'b1, ack)
        i_ccp_host_model.i2c_byte(8'h3c, ack);
        i_ccp_host_model.i2c_byte(8'h4d, ack);
        `CHK("data ack", 1'b1, ack)
        i_ccp_host_model.i2c_stop();
        check_reg(7'h20, 8'h3c);
        check_reg(7'h21, 8'h4d);
        i_ccp_host_model.i2c_start();
        i_ccp_host_model.i2c_byte(8'h9a, ack);
        i_ccp_host_model.i2c_byte(8'ha0, ack);
        i_ccp_host_model.i2c_stop();
        i_ccp_host_model.i2c_start();
        i_ccp_host_model.i2c_byte(8'h9b, ack);
        `CHK("read ack", 1'b1, ack)
        i_ccp_host_model.i2c_read(1'b0, rd);
        `CHK("i2c read first", 8'h3c, rd)
        i_ccp_host_model.i2c_read(1'b1, rd);
        `CHK("i2c read next", 8'h4d, rd)
        i_ccp_host_model.i2c_stop();
        i_ccp_host_model.i2c_start();
        i_ccp_host_model.i2c_byte(8'h9e, ack);
        `CHK("foreign ack", 1'b0, ack)
        i_ccp_host_model.i2c_stop();
        $display("test i2c done");
    endtask

    initial begin
        #200000;
        errors++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        do_reset();
        test_power();
        test_spi();
        test_irq();
        test_i2c();
        summarize();
    end
endmodule
